// ---- logic/mst_status_irq.sv ----
// Status, interrupt and power-state sequencer of a pluggable module.
// Assumes APB from a host bridge on clk, and asynchronous pins for the
// reset pin, low-power pin, management bus clock/data and fault conditions.
module mst_status_irq #(
  parameter int unsigned INIT_MS   = 1000,
  parameter int unsigned WAKE_MS   = 200,
  parameter int unsigned US_PER_MS = 1000
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [7:0]                 paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       module_reset_n_pin,
  input  wire logic                       low_power_pin,
  input  wire logic                       mgmtScl,
  input  wire logic                       mgmtSda,
  input  wire logic [mst_pkg::LANES-1:0]  rxLossCond,
  input  wire logic [mst_pkg::LANES-1:0]  txFaultCond,
  input  wire logic                       otherCond,
  output logic                            interrupt_request_n,
  output logic                            dataNotReady,
  output logic                            busReady,
  output logic                            powerLevel1,
  output logic [mst_pkg::RATE_W-1:0]      bandwidthSel
);

  localparam int unsigned SYNC_W = mst_pkg::COND_W + 4;
  // Synchronisers reset to the idle pin levels, so no false edge follows.
  localparam logic [SYNC_W-1:0] SYNC_IDLE =
    {1'b1, 1'b0, 1'b1, 1'b1, {mst_pkg::COND_W{1'b0}}};

  logic [SYNC_W-1:0]             syncA;
  logic [SYNC_W-1:0]             syncB;
  logic                          rstPinS;
  logic                          lpPinS;
  logic                          sclS;
  logic                          sdaS;
  logic [mst_pkg::COND_W-1:0]    condS;
  logic [mst_pkg::COND_W-1:0]    condPrev;
  logic [mst_pkg::COND_W-1:0]    condRise;
  logic [mst_pkg::US_CNT_W-1:0]  usCnt;
  logic                          usTick;
  logic [mst_pkg::MS_CNT_W-1:0]  usInMs;
  logic                          msTick;
  logic [mst_pkg::RST_CNT_W-1:0] rstLowCnt;
  logic                          pinReset;
  mst_pkg::mst_state_t           state;
  mst_pkg::mst_state_t           next_state;
  logic [mst_pkg::MS_CNT_W-1:0]  phaseMs;
  logic                          phaseDone;
  logic                          goReady;
  logic                          lowPowerReq;
  mst_pkg::mst_flags_t           flags;
  mst_pkg::mst_flags_t           setVec;
  logic [mst_pkg::FLAG_W-1:0]    clrMask;
  logic [mst_pkg::MASK_W-1:0]    mask;
  logic                          ctrlPdown;
  logic [mst_pkg::RATE_W-1:0]    ctrlRate;
  logic                          pending;
  logic                          apbAccess;
  logic                          apbDone;
  logic                          apbMapped;
  logic [31:0]                   next_prdata;
  logic                          sclPrev;
  logic                          sdaPrev;
  logic                          stopSeen;
  logic                          busEnd;
  logic [mst_pkg::AGE_W-1:0]     txnAgeUs;

  // Two-flop synchroniser for every asynchronous pin; only stage B is read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= SYNC_IDLE;
      syncB <= SYNC_IDLE;
    end else begin
      syncA <= {module_reset_n_pin, low_power_pin, mgmtScl, mgmtSda,
                otherCond, txFaultCond, rxLossCond};
      syncB <= syncA;
    end
  end

  assign rstPinS  = syncB[SYNC_W-1];
  assign lpPinS   = syncB[SYNC_W-2];
  assign sclS     = syncB[SYNC_W-3];
  assign sdaS     = syncB[SYNC_W-4];
  assign condS    = syncB[mst_pkg::COND_W-1:0];
  assign condRise = condS & ~condPrev;

  // Free-running microsecond and millisecond ticks from the system clock.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usCnt  <= '0;
      usInMs <= '0;
    end else begin
      if (usTick) begin
        usCnt <= '0;
      end else begin
        usCnt <= usCnt + 1'b1;
      end
      if (msTick) begin
        usInMs <= '0;
      end else if (usTick) begin
        usInMs <= usInMs + 1'b1;
      end
    end
  end

  assign usTick = (usCnt == mst_pkg::US_CNT_W'(mst_pkg::CYC_PER_US - 1));
  assign msTick = usTick && (usInMs == mst_pkg::MS_CNT_W'(US_PER_MS - 1));

  // Reset pin filter; a glitch shorter than the minimum pulse is ignored.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstLowCnt <= '0;
      pinReset  <= 1'b0;
    end else if (rstPinS) begin
      rstLowCnt <= '0;
      pinReset  <= 1'b0;
    end else if (rstLowCnt ==
                 mst_pkg::RST_CNT_W'(mst_pkg::RESET_PULSE_CYC - 1)) begin
      pinReset  <= 1'b1;
    end else begin
      rstLowCnt <= rstLowCnt + 1'b1;
    end
  end

  // Either the pin or the power-down bit asks for power level 1.
  assign lowPowerReq = lpPinS || ctrlPdown;

  // Phase timer runs in milliseconds only while initialising or waking.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseMs <= '0;
    end else if (pinReset || (next_state != state) ||
                 ((state != mst_pkg::ST_INIT) &&
                  (state != mst_pkg::ST_WAKE))) begin
      phaseMs <= '0;
    end else if (msTick && !phaseDone) begin
      phaseMs <= phaseMs + 1'b1;
    end
  end

  assign phaseDone = (state == mst_pkg::ST_INIT)
                   ? (phaseMs >= mst_pkg::MS_CNT_W'(INIT_MS))
                   : (phaseMs >= mst_pkg::MS_CNT_W'(WAKE_MS));

  // Next state: the init delay stays well inside the readiness limits.
  always_comb begin
    next_state = state;
    case (state)
      mst_pkg::ST_INIT: begin
        if (phaseDone) next_state = mst_pkg::ST_READY;
      end
      mst_pkg::ST_READY: begin
        if (lowPowerReq) next_state = mst_pkg::ST_LOWPWR;
      end
      mst_pkg::ST_LOWPWR: begin
        if (!lowPowerReq) next_state = mst_pkg::ST_WAKE;
      end
      mst_pkg::ST_WAKE: begin
        if (lowPowerReq) begin
          next_state = mst_pkg::ST_LOWPWR;
        end else if (phaseDone) begin
          next_state = mst_pkg::ST_READY;
        end
      end
      default: next_state = mst_pkg::ST_INIT;
    endcase
  end

  assign goReady = (next_state == mst_pkg::ST_READY) &&
                   (state != mst_pkg::ST_READY) && !pinReset;

  // State register; a filtered pin reset restarts initialisation.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= mst_pkg::ST_INIT;
    end else if (pinReset) begin
      state <= mst_pkg::ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Readiness and power outputs, all registered.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataNotReady <= 1'b1;
      busReady     <= 1'b0;
      powerLevel1  <= 1'b0;
      bandwidthSel <= mst_pkg::RATE_RESET;
    end else begin
      dataNotReady <= (next_state != mst_pkg::ST_READY) || pinReset;
      if (pinReset) begin
        busReady <= 1'b0;
      end else if (goReady) begin
        busReady <= 1'b1;
      end
      powerLevel1  <= lowPowerReq;
      bandwidthSel <= ctrlRate;
    end
  end

  // Condition edges set flags; the readiness event is raised with it.
  always_comb begin
    setVec          = '0;
    setVec.rxLoss   = condRise[mst_pkg::LANES-1:0];
    setVec.txFault  = condRise[2*mst_pkg::LANES-1:mst_pkg::LANES];
    setVec.other    = condRise[mst_pkg::COND_W-1];
    setVec.readyEvt = goReady;
  end

  // Flags are sticky; a set in the clearing cycle wins over the clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags    <= '0;
      condPrev <= '0;
    end else if (pinReset) begin
      flags    <= '0;
      condPrev <= condS;
    end else begin
      flags    <= (flags & ~clrMask) | setVec;
      condPrev <= condS;
    end
  end

  // Masked flags never reach the line; the readiness event is unmasked.
  assign pending = flags.readyEvt ||
                   (|(flags[mst_pkg::MASK_W-1:0] & ~mask));

  // Interrupt line follows pending state one cycle later.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_request_n <= 1'b1;
    end else begin
      interrupt_request_n <= !pending;
    end
  end

  // Management bus stop detector: deadlines start at the next SCL fall.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev  <= 1'b1;
      sdaPrev  <= 1'b1;
      stopSeen <= 1'b0;
      txnAgeUs <= '0;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      if (sclS && sclPrev && sdaS && !sdaPrev) begin
        stopSeen <= 1'b1;
      end else if (busEnd) begin
        stopSeen <= 1'b0;
      end
      if (busEnd) begin
        txnAgeUs <= '0;
      end else if (usTick && (txnAgeUs != '1)) begin
        txnAgeUs <= txnAgeUs + 1'b1;
      end
    end
  end

  assign busEnd = stopSeen && sclPrev && !sclS;

  // APB slave with one wait state; writes and read clears act at completion.
  assign apbAccess = psel && penable;
  assign apbDone   = apbAccess && pready;
  assign apbMapped = (paddr == mst_pkg::ADDR_STATUS) ||
                     (paddr == mst_pkg::ADDR_FLAGS)  ||
                     (paddr == mst_pkg::ADDR_MASK)   ||
                     (paddr == mst_pkg::ADDR_CTRL)   ||
                     (paddr == mst_pkg::ADDR_TXNAGE);
  // Only the bits that the reader actually saw are cleared.
  assign clrMask   = (apbDone && !pwrite && (paddr == mst_pkg::ADDR_FLAGS))
                   ? prdata[mst_pkg::FLAG_W-1:0] : '0;

  // Read mux; unmapped addresses return zero.
  always_comb begin
    next_prdata = '0;
    case (paddr)
      mst_pkg::ADDR_STATUS: begin
        next_prdata[mst_pkg::STATUS_DNR_BIT]    = dataNotReady;
        next_prdata[mst_pkg::STATUS_LP_BIT]     = powerLevel1;
        next_prdata[mst_pkg::STATUS_BUSRDY_BIT] = busReady;
        next_prdata[mst_pkg::STATUS_STATE_LSB +: 2] = state;
      end
      mst_pkg::ADDR_FLAGS:  next_prdata[mst_pkg::FLAG_W-1:0] = flags;
      mst_pkg::ADDR_MASK:   next_prdata[mst_pkg::MASK_W-1:0] = mask;
      mst_pkg::ADDR_CTRL: begin
        next_prdata[mst_pkg::CTRL_PDOWN_BIT] = ctrlPdown;
        next_prdata[mst_pkg::CTRL_RATE_LSB +: mst_pkg::RATE_W] = ctrlRate;
      end
      mst_pkg::ADDR_TXNAGE: next_prdata[mst_pkg::AGE_W-1:0] = txnAgeUs;
      default:              next_prdata = '0;
    endcase
  end

  // Bus answer flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= apbAccess && !pready;
      if (apbAccess && !pready) begin
        pslverr <= !apbMapped;
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // Writable registers; the pin reset returns them to defaults too.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask      <= mst_pkg::MASK_RESET;
      ctrlPdown <= mst_pkg::PDOWN_RESET;
      ctrlRate  <= mst_pkg::RATE_RESET;
    end else if (pinReset) begin
      mask      <= mst_pkg::MASK_RESET;
      ctrlPdown <= mst_pkg::PDOWN_RESET;
      ctrlRate  <= mst_pkg::RATE_RESET;
    end else if (apbDone && pwrite) begin
      if (paddr == mst_pkg::ADDR_MASK) begin
        mask <= pwdata[mst_pkg::MASK_W-1:0];
      end
      if (paddr == mst_pkg::ADDR_CTRL) begin
        ctrlPdown <= pwdata[mst_pkg::CTRL_PDOWN_BIT];
        ctrlRate  <= pwdata[mst_pkg::CTRL_RATE_LSB +: mst_pkg::RATE_W];
      end
    end
  end

  // Checks on the sequencing above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_pin_filter: assert property ($rose(pinReset) |-> !$past(rstPinS) &&
    $past(rstLowCnt) >= 9'(mst_pkg::RESET_PULSE_CYC - 2))
    else $error("pin reset taken before the minimum pulse");
  a_init_bound: assert property (state == mst_pkg::ST_INIT |->
    phaseMs <= 12'(INIT_MS) && INIT_MS < mst_pkg::INIT_LIMIT_MS)
    else $error("initialisation overran its limit");
  a_bus_ready_state: assert property ($rose(busReady) |->
    state == mst_pkg::ST_READY && $past(state) != mst_pkg::ST_READY)
    else $error("bus readiness not tied to entering ready");
  a_dnr_clear_irq: assert property ($fell(dataNotReady) && !pinReset |->
    flags.readyEvt ##1 !interrupt_request_n)
    else $error("data-not-ready cleared without interrupt");
  a_lowpwr_fast: assert property (lowPowerReq |=> powerLevel1)
    else $error("power level 1 not entered in time");
  a_wake_bound: assert property (state == mst_pkg::ST_WAKE |->
    phaseMs <= 12'(WAKE_MS) && WAKE_MS < mst_pkg::WAKE_LIMIT_MS)
    else $error("wake overran its limit");
  a_irq_assert: assert property (pending |=> !interrupt_request_n)
    else $error("interrupt not asserted for pending flag");
  a_irq_release: assert property (!pending |=> interrupt_request_n)
    else $error("interrupt not released");
  a_rx_flag_set: assert property ((|condRise[3:0]) && !pinReset |=>
    (flags.rxLoss & $past(condRise[3:0])) == $past(condRise[3:0]))
    else $error("receive-loss flag not set");
  a_masked_quiet: assert property (!flags.readyEvt &&
    ((flags[8:0] & ~mask) == 9'h000) ##1 !flags.readyEvt |->
    interrupt_request_n)
    else $error("masked flag drove interrupt");
  a_rate_follow: assert property (ctrlRate != bandwidthSel |=>
    bandwidthSel == $past(ctrlRate))
    else $error("bandwidth select lagged");
  a_bus_end_age: assert property (busEnd |=> txnAgeUs == 16'h0000)
    else $error("transaction age not restarted");
  a_tick_spacing: assert property (usTick |=> !usTick [*8])
    else $error("microsecond tick too frequent");

  c_enter_ready: cover property (goReady);
  c_lowpwr_cycle: cover property (state == mst_pkg::ST_LOWPWR ##1
    state == mst_pkg::ST_WAKE);
  c_flag_cleared: cover property (|clrMask);
  c_bus_end: cover property (busEnd);

endmodule : mst_status_irq

// ---- logic/mst_pkg.sv ----
// Package for the module status, interrupt and power-state timing block.
// Assumes a 200 MHz system clock and an APB register port with 32-bit data.
package mst_pkg;

  // Clock and timing figures.
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned US_NS          = 1000;
  localparam int unsigned CYC_PER_US     = US_NS / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_US = 2;
  localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_US * CYC_PER_US;
  localparam int unsigned INIT_LIMIT_MS  = 2000;
  localparam int unsigned WAKE_LIMIT_MS  = 300;
  localparam int unsigned US_CNT_W       = 8;
  localparam int unsigned RST_CNT_W      = 9;
  localparam int unsigned MS_CNT_W       = 12;
  localparam int unsigned AGE_W          = 16;

  // Register byte addresses on the APB port.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_TXNAGE = 8'h10;

  // Field layouts.
  localparam int unsigned STATUS_DNR_BIT    = 0;
  localparam int unsigned STATUS_LP_BIT     = 1;
  localparam int unsigned STATUS_BUSRDY_BIT = 2;
  localparam int unsigned STATUS_STATE_LSB  = 4;
  localparam int unsigned CTRL_PDOWN_BIT    = 0;
  localparam int unsigned CTRL_RATE_LSB     = 1;
  localparam int unsigned RATE_W            = 2;
  localparam int unsigned LANES             = 4;
  localparam int unsigned FLAG_W            = 10;
  localparam int unsigned MASK_W            = 9;
  localparam int unsigned COND_W            = 9;

  // Reset values.
  localparam logic [MASK_W-1:0] MASK_RESET  = 9'h000;
  localparam logic [RATE_W-1:0] RATE_RESET  = 2'h0;
  localparam logic              PDOWN_RESET = 1'b0;

  // Latched event flags; readyEvt is the unmaskable readiness event.
  typedef struct packed {
    logic             readyEvt;
    logic             other;
    logic [LANES-1:0] txFault;
    logic [LANES-1:0] rxLoss;
  } mst_flags_t;

  // Power and readiness states, Gray coded from INIT to WAKE; WAKE to READY flips both bits.
  typedef enum logic [1:0] {
    ST_INIT   = 2'h0,
    ST_READY  = 2'h1,
    ST_LOWPWR = 2'h3,
    ST_WAKE   = 2'h2
  } mst_state_t;

endpackage : mst_pkg

// ---- sim/mst_mgmt_host.sv ----
// Host model for the management bus: start, ten clocked bits, stop.
// Assumes pull-ups on both lines, so both idle high between frames.
module mst_mgmt_host (
  input  wire logic go,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 32ns;

  // The clock stands high outside frames; a real host leaves it so.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    forever begin
      @(posedge go);
      sda = 1'b0;
      #HALF;
      for (int i = 0; i < 10; i++) begin
        scl = 1'b0;
        #(HALF / 2);
        sda = (i == 9) ? 1'b0 : i[0];
        #(HALF / 2);
        scl = 1'b1;
        #HALF;
      end
      sda = 1'b1;
    end
  end
endmodule : mst_mgmt_host

// ---- sim/tb_mst_status_irq.sv ----
// Self-checking bench for the status, interrupt and power-state block.
// Assumes shortened millisecond figures and a 200 MHz clock.
module tb_mst_status_irq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UPM   = 2;
  localparam int INITM = 3;
  localparam int WAKEM = 2;
  localparam int MSC   = UPM * mst_pkg::CYC_PER_US;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        rstPinN, lpPin, go, scl, sda, irqN, dnr, busRdy, pl1, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ev;
  logic [3:0]  rxC, txC;
  logic        oth;
  logic [1:0]  bw, rate;
  int          n_mismatch = 0, compares = 0, cyc = 0, seed = 8157;
  int          n, ln, k;
  wire  [2:0]  obs = {pl1, dnr, irqN};

  mst_status_irq #(.INIT_MS(INITM), .WAKE_MS(WAKEM), .US_PER_MS(UPM))
    mst_status_irq_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_reset_n_pin(rstPinN), .low_power_pin(lpPin), .mgmtScl(scl),
    .mgmtSda(sda), .rxLossCond(rxC), .txFaultCond(txC), .otherCond(oth),
    .interrupt_request_n(irqN), .dataNotReady(dnr), .busReady(busRdy),
    .powerLevel1(pl1), .bandwidthSel(bw));
  mst_mgmt_host mst_mgmt_host_inst (.go(go), .scl(scl), .sda(sda));

  // Clock; a cycle ceiling cuts a hang short well past the longest run.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task check(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the global cycle ceiling ends a wait for the answer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rdc

  // Bounded wait for one observed output to reach a level.
  task waitfor(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : waitfor

  function logic [31:0] flagv(input int kind, input int l);
    return (kind == 2) ? 32'h100 : 32'h1 << (l + 4 * kind);
  endfunction : flagv

  task pulse(input int kind, input int l);
    @(posedge clk);
    if (kind == 0) rxC[l] <= 1'b1;
    else if (kind == 1) txC[l] <= 1'b1;
    else oth <= 1'b1;
    repeat (3) @(posedge clk);
    rxC <= 4'h0;
    txC <= 4'h0;
    oth <= 1'b0;
  endtask : pulse

  // Readiness: not early, then interrupt, then the read releases it.
  task ready(input int ms);
    waitfor(1, 1'b0, ms * MSC + 40);
    // The phase counts whole free-running millisecond ticks, so it may end
    // up to one millisecond early but never sooner.
    check("ready time", 32'(n >= (ms - 1) * MSC), 32'h1);
    waitfor(0, 1'b0, 3);
    check("irq ready", irqN, 1'b0);
    check("bus ready", busRdy, 1'b1);
    rdc(mst_pkg::ADDR_FLAGS, 32'h200, "ready flag");
    waitfor(0, 1'b1, 3);
    check("irq release", irqN, 1'b1);
  endtask : ready

  // Main sequence: each group below exercises one behaviour.
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, go, oth} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {rstPinN, lpPin} = 2'b10;
    rxC = 4'h0;
    txC = 4'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(mst_pkg::ADDR_STATUS, 32'h1, "status init");
    ready(INITM);
    rdc(mst_pkg::ADDR_STATUS, 32'h14, "status ready");
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    for (k = 0; k < 9; k++) begin
      ln = $random(seed) & 3;
      pulse(k % 3, ln);
      waitfor(0, 1'b0, 10);
      check("irq cond", irqN, 1'b0);
      ev = flagv(k % 3, ln);
      rdc(mst_pkg::ADDR_FLAGS, ev, "flag");
      waitfor(0, 1'b1, 3);
      check("irq clear", irqN, 1'b1);
    end
    apb(1'b1, mst_pkg::ADDR_MASK, 32'h1FF);
    rdc(mst_pkg::ADDR_MASK, 32'h1FF, "mask rw");
    pulse(1, 2);
    repeat (10) @(posedge clk);
    check("irq masked", irqN, 1'b1);
    apb(1'b1, mst_pkg::ADDR_MASK, 32'h0);
    waitfor(0, 1'b0, 3);
    check("irq unmasked", irqN, 1'b0);
    rdc(mst_pkg::ADDR_FLAGS, 32'h40, "masked flag");
    rate = 2'($random(seed));
    for (k = 0; k < 4; k++) begin
      rate = rate + 2'h1;
      apb(1'b1, mst_pkg::ADDR_CTRL, {29'h0, rate, 1'b0});
      repeat (2) @(posedge clk);
      check("rate", bw, rate);
      rdc(mst_pkg::ADDR_CTRL, {29'h0, rate, 1'b0}, "ctrl rw");
    end
    apb(1'b1, mst_pkg::ADDR_CTRL, {29'h0, rate, 1'b1});
    waitfor(2, 1'b1, 10);
    check("pdown", pl1, 1'b1);
    rdc(mst_pkg::ADDR_STATUS, 32'h37, "status lowpwr");
    apb(1'b1, mst_pkg::ADDR_CTRL, {29'h0, rate, 1'b0});
    ready(WAKEM);
    lpPin <= 1'b1;
    waitfor(2, 1'b1, 10);
    check("lp pin", pl1, 1'b1);
    lpPin <= 1'b0;
    ready(WAKEM);
    apb(1'b1, mst_pkg::ADDR_MASK, 32'h0F0);
    rstPinN <= 1'b0;
    repeat (300) @(posedge clk);
    rstPinN <= 1'b1;
    repeat (10) @(posedge clk);
    check("short pin", dnr, 1'b0);
    rstPinN <= 1'b0;
    repeat (450) @(posedge clk);
    check("long pin", dnr, 1'b1);
    rstPinN <= 1'b1;
    rdc(mst_pkg::ADDR_MASK, 32'h0, "mask cleared");
    ready(INITM);
    // With no bus end seen yet the age has run since reset.
    apb(1'b0, mst_pkg::ADDR_TXNAGE, 32'h0);
    check("age idle", 32'(rd[15:0] > 16'h2), 32'h1);
    // Go must fall and rest a clock before it rises for the next frame.
    for (k = 0; k < 2; k++) begin
      go <= 1'b1;
      repeat (400) @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
    end
    apb(1'b0, mst_pkg::ADDR_TXNAGE, 32'h0);
    check("age err", err, 1'b0);
    check("age width", rd[31:16], 16'h0);
    // The second frame's first clock fall ends the first frame, about two
    // microseconds before the read, so one or two ticks have passed.
    ev = 32'(rd[15:0] >= 16'h1 && rd[15:0] <= 16'h2);
    check("age restart", ev, 32'h1);
    end_sim();
  end
endmodule : tb_mst_status_irq
